// ==== include/acs_regs.vh ====
// Register map, field positions and reset values of the converter status block
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// Bus geometry
`define ACS_ADDR_W          12
`define ACS_DATA_W          32

// Register byte offsets
`define ACS_OFF_STATUS      12'h000
`define ACS_OFF_CTRL_ONE    12'h004
`define ACS_OFF_WD_HIGH     12'h024
`define ACS_OFF_WD_LOW      12'h028

// Status fields
`define ACS_ST_WD_EVENT     0
`define ACS_ST_REG_DONE     1
`define ACS_ST_INJ_DONE     2
`define ACS_ST_INJ_START    3
`define ACS_ST_REG_START    4
`define ACS_ST_W            5

// Control one fields
`define ACS_C1_SEL_LSB      0
`define ACS_C1_SEL_MSB      4
`define ACS_C1_SEL_W        5
`define ACS_C1_REG_IEN      5
`define ACS_C1_WD_IEN       6
`define ACS_C1_INJ_IEN      7
`define ACS_C1_SCAN_EN      8
`define ACS_C1_W            9

// Reset values
`define ACS_RST_STATUS      5'h00
`define ACS_RST_CTRL_ONE    9'h000
`define ACS_RST_WD_HIGH     12'hfff
`define ACS_RST_WD_LOW      12'h000

`endif

// ==== core/acs_ctrl.v ====
// Status flags, interrupt enables and watchdog compare of the converter, APB slave
// Contract
// RQ1: Watchdog event sets status bit 0; writing 0 clears, writing 1 ignored.
// RQ2: Status bit 1 set on regular conversion done; cleared only by writing 0.
// RQ3: Status bit 2 set on injected conversion done; cleared by writing 0.
// RQ4: Status bit 3 set when injected conversion starts; cleared by writing 0.
// RQ5: Status bit 4 set when regular conversion starts; cleared by writing 0.
// RQ6: Status bits 31 to 5 read zero and ignore writes.
// RQ7: Control bits 4:0 select watchdog input, codes 0 to 17 valid.
// RQ8: Control bit 5 enables the regular completion interrupt.
// RQ9: Control bit 6 enables watchdog interrupt; in scan mode also aborts scan.
// RQ10: Control bit 7 enables the injected completion interrupt.
// RQ11: In scan mode completion interrupts come only after the last channel.
// RQ12: A converted value outside high and low thresholds is a watchdog event.
// RQ13: Interrupt high while any flag set with its enable; low otherwise.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "acs_regs.vh"

module acs_ctrl #(
    parameter SAMPLE_W = 12
) (
    // Clock, reset and enable
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   clk_en,
    // APB slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`ACS_ADDR_W-1:0] paddr,
    input  wire [`ACS_DATA_W-1:0] pwdata,
    output reg  [`ACS_DATA_W-1:0] prdata,
    output reg                    pready,
    output reg                    pslverr,
    // Conversion events from the sequencer
    input  wire                   regular_start,
    input  wire                   regular_done,
    input  wire                   regular_last,
    input  wire                   injected_start,
    input  wire                   injected_done,
    input  wire                   injected_last,
    // Converted samples
    input  wire                   sample_valid,
    input  wire [4:0]             sample_channel,
    input  wire [SAMPLE_W-1:0]    sample_value,
    // Control towards the sequencer
    output reg  [4:0]             watchdog_input_select,
    output reg                    sequence_scan_en,
    output reg                    scan_abort,
    // Interrupt
    output reg                    irq
);

    // Status flags
    reg                       watchdog_event_flag;
    reg                       regular_done_flag;
    reg                       injected_done_flag;
    reg                       injected_started_flag;
    reg                       regular_started_flag;

    // Control one enables
    reg                       regular_done_irq_en;
    reg                       watchdog_irq_en;
    reg                       injected_done_irq_en;

    // Watchdog window
    reg  [SAMPLE_W-1:0]       wd_high;
    reg  [SAMPLE_W-1:0]       wd_low;

    // Reset images, fields picked out where each register is cleared
    localparam [`ACS_ST_W-1:0] RST_STATUS = `ACS_RST_STATUS;
    localparam [`ACS_C1_W-1:0] RST_CTRL   = `ACS_RST_CTRL_ONE;

    // Bus decode
    wire                      access;
    wire                      wr_en;
    wire                      rd_en;
    wire                      hit_status;
    wire                      hit_ctrl;
    wire                      hit_high;
    wire                      hit_low;
    wire                      hit_any;
    wire                      unmapped;
    wire                      status_wr;
    wire [`ACS_ST_W-1:0]      status_clr;

    // Events
    wire                      wd_chan_match;
    wire                      wd_hit;
    wire                      abort_hit;
    wire                      reg_done_evt;
    wire                      inj_done_evt;

    // Interrupt sources
    wire                      irq_reg_src;
    wire                      irq_wd_src;
    wire                      irq_inj_src;

    // Next values
    reg                       next_watchdog_event_flag;
    reg                       next_regular_done_flag;
    reg                       next_injected_done_flag;
    reg                       next_injected_started_flag;
    reg                       next_regular_started_flag;
    reg                       next_irq;
    reg  [`ACS_DATA_W-1:0]    next_prdata;

    // Value outside the inclusive window
    function out_of_window;
        input [SAMPLE_W-1:0] value;
        input [SAMPLE_W-1:0] high;
        input [SAMPLE_W-1:0] low;
        begin
            out_of_window = (value > high) || (value < low);
        end
    endfunction

    // Full-address compare; partial decode would alias the thresholds
    function addr_hit;
        input [`ACS_ADDR_W-1:0] addr;
        input [`ACS_ADDR_W-1:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // Flag update where a hardware set beats a software clear
    function flag_update;
        input current;
        input set;
        input clear;
        begin
            flag_update = set | (current & ~clear);
        end
    endfunction

    // One wait state: the access phase ends on the second edge after penable rises
    assign access     = psel & penable & ~pready;
    assign wr_en      = access & pwrite;
    assign rd_en      = access & ~pwrite;

    assign hit_status = addr_hit(paddr, `ACS_OFF_STATUS);
    assign hit_ctrl   = addr_hit(paddr, `ACS_OFF_CTRL_ONE);
    assign hit_high   = addr_hit(paddr, `ACS_OFF_WD_HIGH);
    assign hit_low    = addr_hit(paddr, `ACS_OFF_WD_LOW);
    assign hit_any    = hit_status | hit_ctrl | hit_high | hit_low;
    assign unmapped   = ~hit_any;

    // Write-zero clear: a one in the write data leaves the flag alone
    assign status_wr  = wr_en & hit_status;
    assign status_clr = {`ACS_ST_W{status_wr}} & ~pwdata[`ACS_ST_W-1:0];

    // Watchdog looks only at the selected input
    assign wd_chan_match = sample_valid & (sample_channel == watchdog_input_select); // RQ7
    assign wd_hit = wd_chan_match
                  & out_of_window(sample_value, wd_high, wd_low);             // RQ12

    // Abort only matters while a scan runs
    assign abort_hit = wd_hit & watchdog_irq_en & sequence_scan_en;           // RQ9

    // Scan mode holds completion back until the sequence ends
    assign reg_done_evt = regular_done & (~sequence_scan_en | regular_last);  // RQ11
    assign inj_done_evt = injected_done & (~sequence_scan_en | injected_last); // RQ11

    // Status next state
    always @* begin
        next_watchdog_event_flag   = flag_update(watchdog_event_flag,
                                                 wd_hit,
                                                 status_clr[`ACS_ST_WD_EVENT]);  // RQ1
        next_regular_done_flag     = flag_update(regular_done_flag,
                                                 reg_done_evt,
                                                 status_clr[`ACS_ST_REG_DONE]);  // RQ2
        next_injected_done_flag    = flag_update(injected_done_flag,
                                                 inj_done_evt,
                                                 status_clr[`ACS_ST_INJ_DONE]);  // RQ3
        next_injected_started_flag = flag_update(injected_started_flag,
                                                 injected_start,
                                                 status_clr[`ACS_ST_INJ_START]); // RQ4
        next_regular_started_flag  = flag_update(regular_started_flag,
                                                 regular_start,
                                                 status_clr[`ACS_ST_REG_START]); // RQ5
    end

    // Interrupt sources from the flags as they will stand
    assign irq_reg_src = next_regular_done_flag & regular_done_irq_en;        // RQ8
    assign irq_wd_src  = next_watchdog_event_flag & watchdog_irq_en;          // RQ9
    assign irq_inj_src = next_injected_done_flag & injected_done_irq_en;      // RQ10

    // Start flags never interrupt: they only tell software a conversion began
    always @* begin
        next_irq = irq_reg_src | irq_wd_src | irq_inj_src;                    // RQ13
    end

    // Read mux, unused bits zero
    always @* begin
        next_prdata = {`ACS_DATA_W{1'b0}};
        if (hit_status) begin
            next_prdata[`ACS_ST_WD_EVENT]  = watchdog_event_flag;
            next_prdata[`ACS_ST_REG_DONE]  = regular_done_flag;
            next_prdata[`ACS_ST_INJ_DONE]  = injected_done_flag;
            next_prdata[`ACS_ST_INJ_START] = injected_started_flag;
            next_prdata[`ACS_ST_REG_START] = regular_started_flag;           // RQ6
        end else if (hit_ctrl) begin
            next_prdata[`ACS_C1_SEL_MSB:`ACS_C1_SEL_LSB] = watchdog_input_select;
            next_prdata[`ACS_C1_REG_IEN] = regular_done_irq_en;
            next_prdata[`ACS_C1_WD_IEN]  = watchdog_irq_en;
            next_prdata[`ACS_C1_INJ_IEN] = injected_done_irq_en;
            next_prdata[`ACS_C1_SCAN_EN] = sequence_scan_en;
        end else if (hit_high) begin
            next_prdata[SAMPLE_W-1:0] = wd_high;
        end else if (hit_low) begin
            next_prdata[SAMPLE_W-1:0] = wd_low;
        end
    end

    // Bus handshake
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= access;
            pslverr <= access & unmapped;
        end
    end

    // Read data stands only in the ready cycle; zero otherwise keeps stale reads off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= {`ACS_DATA_W{1'b0}};
        end else if (clk_en) begin
            if (rd_en) begin
                prdata <= next_prdata;
            end else begin
                prdata <= {`ACS_DATA_W{1'b0}};
            end
        end
    end

    // Status flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_event_flag   <= RST_STATUS[`ACS_ST_WD_EVENT];
            regular_done_flag     <= RST_STATUS[`ACS_ST_REG_DONE];
            injected_done_flag    <= RST_STATUS[`ACS_ST_INJ_DONE];
            injected_started_flag <= RST_STATUS[`ACS_ST_INJ_START];
            regular_started_flag  <= RST_STATUS[`ACS_ST_REG_START];
        end else if (clk_en) begin
            watchdog_event_flag   <= next_watchdog_event_flag;
            regular_done_flag     <= next_regular_done_flag;
            injected_done_flag    <= next_injected_done_flag;
            injected_started_flag <= next_injected_started_flag;
            regular_started_flag  <= next_regular_started_flag;
        end
    end

    // Control one register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_input_select <= RST_CTRL[`ACS_C1_SEL_MSB:`ACS_C1_SEL_LSB];
            regular_done_irq_en   <= RST_CTRL[`ACS_C1_REG_IEN];
            watchdog_irq_en       <= RST_CTRL[`ACS_C1_WD_IEN];
            injected_done_irq_en  <= RST_CTRL[`ACS_C1_INJ_IEN];
            sequence_scan_en      <= RST_CTRL[`ACS_C1_SCAN_EN];
        end else if (clk_en && wr_en && hit_ctrl) begin
            // Reserved select codes are stored; they match no input
            watchdog_input_select <= pwdata[`ACS_C1_SEL_MSB:`ACS_C1_SEL_LSB]; // RQ7
            regular_done_irq_en   <= pwdata[`ACS_C1_REG_IEN];                 // RQ8
            watchdog_irq_en       <= pwdata[`ACS_C1_WD_IEN];                  // RQ9
            injected_done_irq_en  <= pwdata[`ACS_C1_INJ_IEN];                 // RQ10
            sequence_scan_en      <= pwdata[`ACS_C1_SCAN_EN];
        end
    end

    // Watchdog high threshold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_high <= `ACS_RST_WD_HIGH;
        end else if (clk_en && wr_en && hit_high) begin
            wd_high <= pwdata[SAMPLE_W-1:0];                                  // RQ12
        end
    end

    // Watchdog low threshold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_low <= `ACS_RST_WD_LOW;
        end else if (clk_en && wr_en && hit_low) begin
            wd_low <= pwdata[SAMPLE_W-1:0];                                   // RQ12
        end
    end

    // Interrupt and scan abort
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq        <= 1'b0;
            scan_abort <= 1'b0;
        end else if (clk_en) begin
            irq        <= next_irq;                                           // RQ13
            // One pulse per watchdog hit while scanning with the watchdog interrupt enabled; the sequencer stops the scan on it
            scan_abort <= abort_hit;                                          // RQ9
        end
    end

endmodule // acs_ctrl

// ==== sim/acs_ctrl_assertions.sv ====
// Port-level assertions for the converter status and interrupt block
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_chk #(
    parameter SAMPLE_W = 12
) (
    // Clock, reset, bus
    input wire logic                   pclk, presetn, clk_en, psel, penable, pwrite,
    input wire logic [`ACS_ADDR_W-1:0] paddr,
    input wire logic [`ACS_DATA_W-1:0] pwdata, prdata,
    input wire logic                   pready, pslverr,
    // Events and samples
    input wire logic                   regular_start, regular_done, regular_last,
    input wire logic                   injected_start, injected_done, injected_last,
    input wire logic                   sample_valid,
    input wire logic [4:0]             sample_channel,
    input wire logic [SAMPLE_W-1:0]    sample_value,
    // Outputs
    input wire logic [4:0]             watchdog_input_select,
    input wire logic                   sequence_scan_en, scan_abort, irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc; psel && penable && !pready && clk_en; endsequence
    sequence s_quiet; !regular_done && !injected_done && !sample_valid; endsequence
    property p_ans; s_acc |=> pready; endproperty
    property p_pulse; pready && clk_en |=> !pready; endproperty
    property p_err;
        pready |-> pslverr == !(paddr == 0 || paddr == 4 || paddr == 12'h024 || paddr == 12'h028);
    endproperty
    property p_rsv; pready && !pwrite && paddr == 0 |-> prdata[31:5] == 0; endproperty
    property p_sel;
        s_acc ##0 (pwrite && paddr == 12'h004) |=>
            watchdog_input_select == $past(pwdata[4:0]) && sequence_scan_en == $past(pwdata[8]);
    endproperty
    property p_src;
        $rose(irq) |-> $past(regular_done || injected_done || sample_valid || psel && pwrite);
    endproperty
    property p_clr; s_acc ##0 s_quiet ##0 (pwrite && paddr == 0 && pwdata[2:0] == 0) |=> !irq;
    endproperty
    property p_hold;
        sequence_scan_en && clk_en && regular_done && !regular_last && !irq
            && !injected_done && !sample_valid && !psel |=> !irq;
    endproperty
    property p_abort;
        scan_abort |-> $past(sample_valid && sequence_scan_en) || $past(sample_valid, 2);
    endproperty
    a_ans: assert property (p_ans) else $error("access not answered next cycle");
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_err: assert property (p_err) else $error("error flag wrong for address");
    a_rsv: assert property (p_rsv) else $error("reserved status bits not zero");
    a_sel: assert property (p_sel) else $error("control outputs not updated");
    a_src: assert property (p_src) else $error("interrupt rose without cause");
    a_clr: assert property (p_clr) else $error("interrupt kept after clear");
    a_hold: assert property (p_hold) else $error("interrupt before last channel");
    a_abort: assert property (p_abort) else $error("abort without watchdog sample");
endmodule // acs_chk

bind acs_ctrl acs_chk #(.SAMPLE_W(SAMPLE_W)) i_acs_chk (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regular_start(regular_start), .regular_done(regular_done), .regular_last(regular_last),
    .injected_start(injected_start), .injected_done(injected_done),
    .injected_last(injected_last), .sample_valid(sample_valid), .sample_channel(sample_channel),
    .sample_value(sample_value), .watchdog_input_select(watchdog_input_select),
    .sequence_scan_en(sequence_scan_en), .scan_abort(scan_abort), .irq(irq));

// ==== sim/test_adc_status_irq_control.sv ====
// Self-checking bench for the converter status and interrupt block
`timescale 1ns/1ps
module test_adc_status_irq_control;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0, sample_value = 0, hi_val;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, scan_abort, irq, sequence_scan_en, last = 1;
    logic [4:0]  evs = 0, sel = 0, watchdog_input_select;
    logic [32:0] q[$];
    logic [11:0] ra[5] = '{12'h000, 12'h004, 12'h024, 12'h028, 12'h008};
    logic [31:0] rv[5] = '{32'h0, 32'h0, 32'hfff, 32'h0, 32'h0};
    int          n_mismatch = 0, compares = 0, n_abort = 0, en;
    always #5 pclk = ~pclk;
    acs_ctrl i_acs_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .regular_start(evs[4]), .regular_done(evs[1]),
        .regular_last(last), .injected_start(evs[3]), .injected_done(evs[2]),
        .injected_last(last), .sample_valid(evs[0]), .sample_channel(sel),
        .sample_value(sample_value), .watchdog_input_select(watchdog_input_select),
        .sequence_scan_en(sequence_scan_en), .scan_abort(scan_abort), .irq(irq));
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Read data and error flag are judged only in the ready cycle
    always @(posedge pclk) begin
        if (pready === 1'b1 && q.size() > 0) chk({pslverr, prdata}, q.pop_front());
    end
    always @(posedge pclk) if (scan_abort === 1'b1) n_abort++;
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        q.push_back({a != 0 && a != 4 && a != 12'h024 && a != 12'h028, wr ? 32'h0 : e});
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        psel <= 0;
        penable <= 0;
    endtask
    task ev(input int k, input logic l, input logic [11:0] v);
        @(posedge pclk);
        evs[k] <= 1;
        last <= l;
        sample_value <= v;
        @(posedge pclk);
        evs <= 0;
    endtask
    task irq_is(input logic e);
        @(negedge pclk);
        chk({32'h0, irq}, {32'h0, e});
    endtask
    task end_of_test;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'h0de1));
        sel = 5'($urandom % 18);
        hi_val = 12'h801 + 12'($urandom % 12'h7fe);
        repeat (12) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 5; i++) apb(0, ra[i], 0, rv[i]);
        apb(1, 12'h024, 32'h800, 0);
        apb(1, 12'h028, 32'h100, 0);
        $display("test 1 done");
        apb(1, 4, {24'h0, 3'b111, sel}, 0);
        apb(0, 4, 0, {24'h0, 3'b111, sel});
        for (int k = 0; k < 5; k++) ev(k, 1, hi_val);
        apb(0, 0, 0, 32'h1f);
        irq_is(1);
        apb(1, 0, 32'hffffffff, 0);
        apb(0, 0, 0, 32'h1f);
        for (int k = 0; k < 5; k++) begin
            apb(1, 0, ~(32'h1 << k), 0);
            apb(0, 0, 0, 32'h1f & ~((32'h2 << k) - 1));
        end
        irq_is(0);
        $display("test 2 done");
        for (int i = 0; i < 3; i++) begin
            en = i == 0 ? 6 : i == 1 ? 5 : 7;
            apb(1, 4, {27'h0, sel}, 0);
            ev(i, 1, hi_val);
            irq_is(0);
            apb(1, 4, (32'h1 << en) | sel, 0);
            irq_is(1);
            apb(1, 0, 0, 0);
            irq_is(0);
        end
        $display("test 3 done");
        apb(1, 4, 32'h160 | sel, 0);
        ev(0, 1, 12'h400);
        ev(1, 0, 12'h400);
        apb(0, 0, 0, 0);
        ev(1, 1, 12'h400);
        irq_is(1);
        apb(0, 0, 0, 2);
        apb(1, 0, 0, 0);
        ev(0, 1, hi_val);
        repeat (3) @(posedge pclk);
        chk(33'(n_abort), 33'h1);
        apb(0, 0, 0, 1);
        clk_en <= 0;
        ev(1, 1, hi_val);
        @(posedge pclk);
        clk_en <= 1;
        apb(0, 0, 0, 1);
        $display("test 4 done");
        end_of_test;
    end
endmodule // test_adc_status_irq_control
